/* File: bench/fcu_counter_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// checks
module fcu_counter_props
  import fcu_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // arbitration low bits and outputs
  input wire logic [2:0]  arbitration_id_low,
  input wire logic        irq_request,
  input wire logic [2:0]  irq_priority_level,
  input wire logic [3:0]  arbitration_id,
  input wire logic [15:0] timebase_a,
  input wire logic        timebase_a_en,
  input wire logic [15:0] timebase_b,
  input wire logic        timebase_b_en
);
  logic [1:0] up_r;
  logic       cw_r;
  logic       sw_r;
  logic       pw_r;
  logic       run_r;
  logic [5:0] cfg_r;
  wire logic  take;
  wire logic  aw;
  assign take = hsel & htrans[1] & hready;
  assign aw   = take & hwrite & (hsize == FCU_HSIZE_WORD);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {up_r, cw_r, sw_r, pw_r, run_r, cfg_r} <= '0;
    end
    else
    begin
      up_r  <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
      cw_r  <= aw & (haddr == FCU_OFF_COUNT_VALUE);
      sw_r  <= aw & (haddr == FCU_OFF_STATUS_IRQ_CONTROL);
      pw_r  <= aw & (haddr == FCU_OFF_PRESCALER_CTRL);
      run_r <= pw_r ? hwdata[FCU_BIT_RUN] : run_r;
      cfg_r <= sw_r ? {hwdata[14:11], hwdata[9:8]} : cfg_r;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || up_r != 2'h3);
  AST_RD_WAIT: assert property (take & !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (take & hwrite |=> hreadyout)
    else $error("write stalled");
  AST_CFG: assert property (sw_r |-> ##[1:2]
    {irq_priority_level, arbitration_id[3], timebase_a_en, timebase_b_en} == cfg_r)
    else $error("control outputs wrong");
  AST_ARB: assert property (arbitration_id[2:0] == $past(arbitration_id_low))
    else $error("arbitration low bits wrong");
  AST_REQ_LVL: assert property (irq_request |-> irq_priority_level != 3'h0)
    else $error("request at level zero");
  AST_OVF: assert property ($past(timebase_a) == 16'hFFFF && timebase_a == 16'h0000
    && !$past(cw_r) && irq_priority_level != 3'h0 |-> ##[0:2] irq_request)
    else $error("overflow gave no request");
  AST_W0: assert property ($past(cw_r) && $past(timebase_a) == 16'hFFFF
    && timebase_a == 16'h0000 && !$past(irq_request) |-> !irq_request [*3])
    else $error("count write raised request");
  AST_HOLD: assert property (!run_r && !$past(run_r) && !$past(run_r, 2)
    && !$past(run_r, 3) && !$past(cw_r) |-> $stable(timebase_a))
    else $error("counted while stopped");
  AST_TB_EQ: assert property (!$past(cw_r) |-> timebase_b == timebase_a
    && (timebase_a == $past(timebase_a) || timebase_a == $past(timebase_a) + 16'h0001))
    else $error("time-base count jumped");
  COV_OVF: cover property ($rose(irq_request));
  COV_RD: cover property (take & !hwrite);
  COV_CFG: cover property (sw_r);
endmodule // fcu_counter_props
bind fcu_counter fcu_counter_props i_props (.mclk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .arbitration_id_low, .irq_request,
  .irq_priority_level, .arbitration_id, .timebase_a, .timebase_a_en, .timebase_b,
  .timebase_b_en);
`default_nettype wire

/* File: bench/fcu_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// count pin source
module fcu_pin_src
(
  input  wire logic  mclk,
  output logic       count_input_pin,
  output logic [2:0] arbitration_id_low
);
  initial
  begin
    count_input_pin    = 1'b0;
    arbitration_id_low = 3'h5;
  end
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      count_input_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      count_input_pin <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task automatic level(input logic l);
    @(posedge mclk);
    count_input_pin <= l;
  endtask
endmodule // fcu_pin_src
`default_nettype wire

/* File: bench/free_running_counter_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// testbench
module free_running_counter_control_test
  import fcu_pkg::*;
;
  localparam logic [7:0] ST = FCU_OFF_STATUS_IRQ_CONTROL;
  localparam logic [7:0] CN = FCU_OFF_COUNT_VALUE;
  localparam logic [7:0] EV = FCU_OFF_EVENT_STATUS;
  localparam logic [7:0] MK = FCU_OFF_EVENT_MASK;
  localparam logic [7:0] PS = FCU_OFF_PRESCALER_CTRL;
  localparam logic [7:0] UM = 8'h14;
  logic        mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, arbitration_id_low, irq_priority_level;
  logic [31:0] hwdata, hrdata, q;
  logic        count_input_pin, irq_request, timebase_a_en, timebase_b_en, irq;
  logic [3:0]  arbitration_id;
  logic [15:0] timebase_a, timebase_b;
  int          n_mismatch;
  int          tests_run;
  assign hready = hreadyout;
  fcu_counter i_dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .count_input_pin, .arbitration_id_low,
    .irq_request, .irq_priority_level, .arbitration_id, .timebase_a, .timebase_a_en,
    .timebase_b, .timebase_b_en, .irq);
  fcu_pin_src i_pin (.mclk, .count_input_pin, .arbitration_id_low);
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      n_mismatch++;
    end
  endtask
  task automatic rdy;
    logic ok;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge mclk);
      ok = (hready === 1'b1);
      q = hrdata;
      @(posedge mclk);
      if (ok)
        return;
    end
    n_mismatch++;
    final_report;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    rdy;
    {htrans, hwdata} <= {2'h0, d};
    rdy;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(what, e, q);
  endtask
  task automatic period(output int n);
    logic [15:0] v;
    int k;
    k = 0;
    n = 0;
    @(negedge mclk);
    v = timebase_a;
    while (k < 2 && n < 4000)
    begin
      @(negedge mclk);
      n++;
      if (timebase_a !== v)
      begin
        k++;
        n = (k == 1) ? 0 : n;
        v = timebase_a;
      end
    end
    if (k < 2)
    begin
      n_mismatch++;
      final_report;
    end
  endtask
  task automatic t_reset;
    chk("status", ST, 32'h0);
    chk("count", CN, 32'h0);
    chk("unmapped", UM, 32'h0);
    repeat (40) @(posedge mclk);
    chk("halted", CN, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wr(ST, 32'hFFFF_FFFF);
    chk("status", ST, 32'h0000_7B07);
    cmp("level", 32'h7, irq_priority_level);
    cmp("arb", 32'hD, arbitration_id);
    cmp("resp", 32'h0, hresp);
    for (int k = 0; k < 4; k++)
    begin
      wr(ST, k << 8);
      rd(ST);
      cmp("drive", k, {timebase_a_en, timebase_b_en});
    end
    wr(UM, 32'hFFFF_FFFF);
    chk("unmapped", UM, 32'h0);
    wr(CN, 32'hFFFF_1234);
    chk("count", CN, 32'h1234);
    cmp("timebase", 32'h1234, timebase_b);
    i_pin.level(1'b1);
    wr(ST, 32'h0);
    chk("pin", ST, 32'h80);
    i_pin.level(1'b0);
    repeat (4) @(posedge mclk);
    chk("pin", ST, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_taps;
    int n;
    wr(PS, 32'h1);
    for (int c = 0; c < 6; c++)
    begin
      wr(ST, c);
      period(n);
      cmp("period", (c == 5) ? 64 : 2 << c, n);
    end
    wr(PS, 32'h3);
    wr(ST, 32'h0);
    period(n);
    cmp("period", 32'h3, n);
    wr(PS, 32'hD);
    wr(ST, 32'h5);
    period(n);
    cmp("period", 32'h200, n);
    wr(PS, 32'hF);
    period(n);
    cmp("period", 32'h300, n);
    $display("t_taps done");
  endtask
  task automatic t_ext;
    for (int c = 6; c < 8; c++)
    begin
      wr(ST, c);
      wr(CN, 32'h0);
      i_pin.pulses(3);
      i_pin.level(1'b1);
      repeat (8) @(posedge mclk);
      chk("events", CN, (c == 6) ? 32'h3 : 32'h4);
      i_pin.level(1'b0);
    end
    chk("event", EV, 32'h2);
    $display("t_ext done");
  endtask
  task automatic t_ovf;
    wr(PS, 32'h1);
    wr(MK, 32'h0);
    wr(ST, 32'h3000);
    wr(CN, 32'hFFF0);
    repeat (48) @(posedge mclk);
    cmp("request", 32'h1, irq_request);
    rd(ST);
    cmp("flag", 32'hB000, q & 32'hF000);
    cmp("irq", 32'h0, irq);
    wr(MK, 32'h1);
    chk("mask", MK, 32'h1);
    cmp("irq", 32'h1, irq);
    wr(EV, 32'h3);
    chk("event", EV, 32'h0);
    cmp("irq", 32'h0, irq);
    wr(CN, 32'hFFF8);
    repeat (32) @(posedge mclk);
    wr(ST, 32'h3000);
    rd(ST);
    cmp("flag", 32'h8000, q & 32'h8000);
    wr(ST, 32'h3000);
    rd(ST);
    cmp("flag", 32'h0, q & 32'h8000);
    cmp("request", 32'h0, irq_request);
    wr(PS, 32'h0);
    wr(EV, 32'h3);
    wr(CN, 32'hFFFF);
    wr(CN, 32'h0);
    rd(ST);
    cmp("flag", 32'h0, q & 32'h8000);
    cmp("request", 32'h0, irq_request);
    chk("event", EV, 32'h0);
    $display("t_ovf done");
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = FCU_HSIZE_WORD;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_regs;
    t_taps;
    t_ext;
    t_ovf;
    final_report;
  end
endmodule // free_running_counter_control_test
`default_nettype wire

/* File: src/fcu_counter.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - overflow_flag sets when the count rolls from FFFF to 0000.
// - flag set with nonzero level raises an interrupt request at that level.
// - an overflow between the arming read and clearing write keeps the flag.
// - 3-bit level field at 14:12, resets to zero, zero disables.
// - bit 11 is the top bit of the arbitration id, rest from outside.
// - each requester needs a unique arbitration id; we present ours.
// - drive bits 9:8 select time-base bus A, B, both or none.
// - bit 7 reads the synchronised pin, read-only, untouched by reset.
// - clock select 000 to 101 picks prescaler taps 1 to 6.
// - clock select 110 counts falling pin edges, 111 rising ones.
// - taps divide by 2..32 or 3..48, tap six 64..512 or 96..768.
// - count_value is a 16-bit read/write register cleared by reset.
// - reserved bits and addresses read zero and ignore writes.
// - nothing counts until software sets the prescaler run bit.
// - writing zero while the count is FFFF sets no overflow.

module fcu_counter
  import fcu_pkg::*;
#(
  parameter int CHAIN_W = 8
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // external count input
  input  wire logic         count_input_pin,
  // arbitration low bits from bus interface unit
  input  wire logic [2:0]   arbitration_id_low,
  // intermodule bus interrupt request
  output logic              irq_request,
  output logic [2:0]        irq_priority_level,
  output logic [3:0]        arbitration_id,
  // time-base buses
  output logic [15:0]       timebase_a,
  output logic              timebase_a_en,
  output logic [15:0]       timebase_b,
  output logic              timebase_b_en,
  // event interrupt
  output logic              irq
);

  // ==========================================================
  // reset synchroniser
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ==========================================================
  // registers
  logic [15:0]          count_r;
  logic [15:0]          count_nxt;
  logic                 overflow_flag_r;
  logic                 overflow_flag_nxt;
  logic                 armed_r;
  logic                 armed_nxt;
  logic [2:0]           level_r;
  logic                 arb_top_r;
  logic                 drive_a_r;
  logic                 drive_b_r;
  logic [2:0]           clk_sel_r;
  logic [2:0]           clk_sel_prev_r;
  logic                 run_r;
  logic                 div3_r;
  logic [1:0]           tap6_r;
  logic [FCU_EVT_W-1:0] evt_status_r;
  logic [FCU_EVT_W-1:0] evt_status_nxt;
  logic [FCU_EVT_W-1:0] evt_mask_r;

  // ==========================================================
  // bus phase tracking
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_r;
  logic        size_ok_r;
  logic        addr_phase;
  logic        wr_en;
  logic        wr_status;
  logic        wr_count;
  logic        wr_evt_status;
  logic        wr_evt_mask;
  logic        wr_presc;
  logic        rd_status;
  logic [31:0] rd_mux;

  assign addr_phase    = hsel && htrans[1] && hready;
  assign wr_en         = wr_pend_r && size_ok_r;
  assign wr_status     = wr_en && (addr_r == FCU_OFF_STATUS_IRQ_CONTROL);
  assign wr_count      = wr_en && (addr_r == FCU_OFF_COUNT_VALUE);
  assign wr_evt_status = wr_en && (addr_r == FCU_OFF_EVENT_STATUS);
  assign wr_evt_mask   = wr_en && (addr_r == FCU_OFF_EVENT_MASK);
  assign wr_presc      = wr_en && (addr_r == FCU_OFF_PRESCALER_CTRL);
  assign rd_status     = rd_pend_r && (addr_r == FCU_OFF_STATUS_IRQ_CONTROL);
  assign hreadyout     = !rd_pend_r;
  assign hresp         = 1'b0;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      size_ok_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      if (addr_phase)
      begin
        addr_r    <= haddr;
        size_ok_r <= (hsize == FCU_HSIZE_WORD);
      end
    end
  end

  // ==========================================================
  // pin synchroniser, no reset so reset leaves it alone
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;

  always_ff @(posedge mclk)
  begin
    pin_meta_r <= count_input_pin;
    pin_sync_r <= pin_meta_r;
    pin_prev_r <= pin_sync_r;
  end

  // ==========================================================
  // prescaler taps
  logic [FCU_TAP_N-1:0] tap_pulse;

  fcu_prescaler #(
    .CHAIN_W   (CHAIN_W)
  ) u_prescaler (
    .mclk      (mclk),
    .rst_n     (rst_sync_n),
    .run       (run_r),
    .div3_sel  (div3_r),
    .tap6_sel  (tap6_r),
    .tap_pulse (tap_pulse)
  );

  // ==========================================================
  // clock source selection
  logic sel_stable;
  logic ext_fall;
  logic ext_rise;
  logic ext_edge;
  logic count_tick;
  logic ovf_event;
  logic flag_clear;

  assign sel_stable = (clk_sel_r == clk_sel_prev_r);
  assign ext_fall   = pin_prev_r && !pin_sync_r;
  assign ext_rise   = !pin_prev_r && pin_sync_r;
  assign ext_edge   = run_r && sel_stable &&
                      (((clk_sel_r == FCU_CLK_EXT_FALL) && ext_fall) ||
                       ((clk_sel_r == FCU_CLK_EXT_RISE) && ext_rise));
  assign count_tick = run_r && sel_stable &&
                      ((clk_sel_r < FCU_CLK_EXT_FALL) ? tap_pulse[clk_sel_r]
                                                      : ext_edge);

  // ==========================================================
  // counter and overflow
  assign count_nxt  = wr_count ? hwdata[15:0]
                    : (count_tick ? count_r + 16'h0001 : count_r);
  assign ovf_event  = count_tick && !wr_count && (count_r == FCU_COUNT_MAX);
  assign flag_clear = wr_status && armed_r && !hwdata[FCU_BIT_OVERFLOW];
  assign overflow_flag_nxt = ovf_event || (overflow_flag_r && !flag_clear);
  assign armed_nxt  = ovf_event ? 1'b0
                    : (rd_status && overflow_flag_r) ? 1'b1
                    : (wr_status ? 1'b0 : armed_r);

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      count_r         <= FCU_COUNT_RESET;
      overflow_flag_r <= 1'b0;
      armed_r         <= 1'b0;
    end
    else
    begin
      count_r         <= count_nxt;
      overflow_flag_r <= overflow_flag_nxt;
      armed_r         <= armed_nxt;
    end
  end

  // ==========================================================
  // control fields
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      level_r        <= FCU_LVL_RESET;
      arb_top_r      <= 1'b0;
      drive_a_r      <= 1'b0;
      drive_b_r      <= 1'b0;
      clk_sel_r      <= FCU_CLK_RESET;
      clk_sel_prev_r <= FCU_CLK_RESET;
      run_r          <= 1'b0;
      div3_r         <= 1'b0;
      tap6_r         <= FCU_TAP6_RESET;
    end
    else
    begin
      clk_sel_prev_r <= clk_sel_r;
      if (wr_status)
      begin
        level_r   <= hwdata[FCU_LVL_HI:FCU_LVL_LO];
        arb_top_r <= hwdata[FCU_BIT_ARB_TOP];
        drive_a_r <= hwdata[FCU_BIT_DRIVE_A];
        drive_b_r <= hwdata[FCU_BIT_DRIVE_B];
        clk_sel_r <= hwdata[FCU_CLK_HI:FCU_CLK_LO];
      end
      if (wr_presc)
      begin
        run_r  <= hwdata[FCU_BIT_RUN];
        div3_r <= hwdata[FCU_BIT_DIV3];
        tap6_r <= hwdata[FCU_TAP6_HI:FCU_TAP6_LO];
      end
    end
  end

  // ==========================================================
  // event status, set wins over write-one-clear
  logic [FCU_EVT_W-1:0] evt_set;

  assign evt_set = {ext_edge, ovf_event};
  assign evt_status_nxt = evt_set |
                          (evt_status_r & ~(wr_evt_status ? hwdata[FCU_EVT_W-1:0] : '0));

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      evt_status_r <= '0;
      evt_mask_r   <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      evt_status_r <= evt_status_nxt;
      if (wr_evt_mask)
      begin
        evt_mask_r <= hwdata[FCU_EVT_W-1:0];
      end
      irq <= |(evt_status_nxt & (wr_evt_mask ? hwdata[FCU_EVT_W-1:0] : evt_mask_r));
    end
  end

  // ==========================================================
  // read mux, reserved bits and addresses read zero
  logic [15:0] status_word;

  assign status_word = {overflow_flag_r, level_r, arb_top_r, 1'b0, drive_a_r, drive_b_r,
                        pin_sync_r, 4'h0, clk_sel_r};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr_r)
      FCU_OFF_STATUS_IRQ_CONTROL: rd_mux = {16'h0000, status_word};
      FCU_OFF_COUNT_VALUE:        rd_mux = {16'h0000, count_r};
      FCU_OFF_EVENT_STATUS:       rd_mux = {30'h0000_0000, evt_status_r};
      FCU_OFF_EVENT_MASK:         rd_mux = {30'h0000_0000, evt_mask_r};
      FCU_OFF_PRESCALER_CTRL:     rd_mux = {28'h000_0000, tap6_r, div3_r, run_r};
      default:                    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend_r)
    begin
      hrdata <= rd_mux;
    end
  end

  // ==========================================================
  // interrupt request and time-base outputs
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_request        <= 1'b0;
      irq_priority_level <= FCU_LVL_RESET;
      arbitration_id     <= 4'h0;
      timebase_a         <= FCU_COUNT_RESET;
      timebase_b         <= FCU_COUNT_RESET;
      timebase_a_en      <= 1'b0;
      timebase_b_en      <= 1'b0;
    end
    else
    begin
      irq_request        <= overflow_flag_nxt && (level_r != 3'h0);
      irq_priority_level <= level_r;
      arbitration_id     <= {arb_top_r, arbitration_id_low};
      timebase_a         <= count_nxt;
      timebase_b         <= count_nxt;
      timebase_a_en      <= drive_a_r;
      timebase_b_en      <= drive_b_r;
    end
  end

endmodule // fcu_counter

`default_nettype wire

/* File: src/fcu_pkg.sv */
package fcu_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] FCU_OFF_STATUS_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] FCU_OFF_COUNT_VALUE        = 8'h04;
  localparam logic [7:0] FCU_OFF_EVENT_STATUS       = 8'h08;
  localparam logic [7:0] FCU_OFF_EVENT_MASK         = 8'h0C;
  localparam logic [7:0] FCU_OFF_PRESCALER_CTRL     = 8'h10;

  // ==========================================================
  // status_irq_control field positions
  localparam int FCU_BIT_OVERFLOW  = 15;
  localparam int FCU_LVL_HI        = 14;
  localparam int FCU_LVL_LO        = 12;
  localparam int FCU_BIT_ARB_TOP   = 11;
  localparam int FCU_BIT_DRIVE_A   = 9;
  localparam int FCU_BIT_DRIVE_B   = 8;
  localparam int FCU_BIT_PIN       = 7;
  localparam int FCU_CLK_HI        = 2;
  localparam int FCU_CLK_LO        = 0;

  // ==========================================================
  // prescaler_ctrl field positions
  localparam int FCU_BIT_RUN       = 0;
  localparam int FCU_BIT_DIV3      = 1;
  localparam int FCU_TAP6_HI       = 3;
  localparam int FCU_TAP6_LO       = 2;

  // ==========================================================
  // event status and mask bits
  localparam int FCU_EVT_OVERFLOW  = 0;
  localparam int FCU_EVT_EXT_EDGE  = 1;
  localparam int FCU_EVT_W         = 2;

  // ==========================================================
  // reset values and counter limits
  localparam logic [15:0] FCU_COUNT_RESET = 16'h0000;
  localparam logic [15:0] FCU_COUNT_MAX   = 16'hFFFF;
  localparam logic [2:0]  FCU_LVL_RESET   = 3'h0;
  localparam logic [2:0]  FCU_CLK_RESET   = 3'h0;
  localparam logic [1:0]  FCU_TAP6_RESET  = 2'h0;

  // ==========================================================
  // clock select codes
  localparam logic [2:0]  FCU_CLK_EXT_FALL = 3'h6;
  localparam logic [2:0]  FCU_CLK_EXT_RISE = 3'h7;
  localparam int          FCU_TAP_N        = 6;

  // ==========================================================
  // bus constants
  localparam logic [2:0]  FCU_HSIZE_WORD = 3'h2;

endpackage

/* File: src/fcu_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module fcu_prescaler
  import fcu_pkg::*;
#(
  parameter int CHAIN_W = 8
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic         div3_sel,
  input  wire logic [1:0]   tap6_sel,
  // tap enables
  output logic [FCU_TAP_N-1:0] tap_pulse
);

  // ==========================================================
  // low n bits of the chain all ones
  function automatic logic low_ones(input logic [CHAIN_W-1:0] cnt, input int n);
    logic [CHAIN_W-1:0] mask;
    mask = CHAIN_W'((1 << n) - 1);
    return &(cnt | ~mask);
  endfunction

  logic [1:0]          base_cnt_r;
  logic [1:0]          base_cnt_nxt;
  logic [CHAIN_W-1:0]  chain_r;
  logic [CHAIN_W-1:0]  chain_nxt;
  logic                base_pulse;
  logic [FCU_TAP_N-1:0] tap_nxt;

  // ==========================================================
  // base divider, by 2 or by 3
  assign base_pulse   = run && (div3_sel ? (base_cnt_r == 2'h2) : (base_cnt_r == 2'h1));
  assign base_cnt_nxt = (!run || base_pulse) ? 2'h0 : base_cnt_r + 2'h1;
  assign chain_nxt    = !run ? '0 : (base_pulse ? chain_r + CHAIN_W'(1) : chain_r);

  // ==========================================================
  // tap decode, taps 2 to 5 twice the previous, tap six 2, 4, 8 or 16 times tap five
  assign tap_nxt[0] = base_pulse;
  genvar k;
  generate
    for (k = 1; k < FCU_TAP_N - 1; k++)
    begin : g_tap
      assign tap_nxt[k] = base_pulse && low_ones(chain_r, k);
    end
  endgenerate
  assign tap_nxt[FCU_TAP_N-1] = base_pulse && low_ones(chain_r, 5 + int'(tap6_sel));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_cnt_r <= 2'h0;
      chain_r    <= '0;
      tap_pulse  <= '0;
    end
    else
    begin
      base_cnt_r <= base_cnt_nxt;
      chain_r    <= chain_nxt;
      tap_pulse  <= tap_nxt;
    end
  end

endmodule // fcu_prescaler

`default_nettype wire
